/* rtl/accel_sample_fifo.sv */
/*
 * Accelerometer frame buffer with APB register access, special frames,
 * down-sampling, pin tags and full/watermark interrupt pins.
 * Assumes odr_tick is a one-cycle pulse per sensor sample and all inputs
 * are synchronous to pclk.
 */
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps

module accel_sample_fifo #(
	parameter int DEPTH = 1024,
	parameter int AW    = 10
) (
	// Clock and reset
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	// APB slave
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [9:0]                           paddr,
	input  wire logic [31:0]                          pwdata,
	output logic      [31:0]                          prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	// Sensor side
	input  wire logic                                 odr_tick,
	input  wire accel_sample_fifo_pkg::sensor_sample_t sample_in,
	input  wire logic [23:0]                          sensor_time,
	input  wire logic                                 irq_pin_a_in,
	input  wire logic                                 irq_pin_b_in,
	// Interrupt pins
	output logic                                      irq_pin_a_out,
	output logic                                      irq_pin_b_out
);

	localparam logic [AW:0] FULL_THR = (AW+1)'(DEPTH - accel_sample_fifo_pkg::FULL_MARGIN);
	localparam logic [AW:0] CAP      = (AW+1)'(DEPTH);

	function automatic logic [2:0] stored_len(input logic [7:0] hdr);
		return (hdr[7:2] == accel_sample_fifo_pkg::SIG_DATA) ?
			accel_sample_fifo_pkg::LEN_DATA : accel_sample_fifo_pkg::LEN_SHORT;
	endfunction : stored_len

	function automatic logic [6:0] downs_mask(input logic [2:0] k);
		return 7'((8'h01 << k) - 8'h01);
	endfunction : downs_mask

	// Registers
	logic [7:0]                           mem [DEPTH];
	logic [7:0]                           downs_reg, mode_reg, source_reg;
	logic [7:0]                           filter_reg, range_reg, pin_sel_reg, routing_reg;
	logic [12:0]                          wtm_reg;
	logic [2:0]                           active_downs_reg;
	logic [6:0]                           tick_cnt_reg;
	logic [AW-1:0]                        wr_ptr_reg, rd_ptr_reg;
	logic [AW:0]                          fill_reg, fill_next;
	logic [7:0]                           skip_cnt_reg;
	logic [1:0]                           cfg_flags_reg;
	logic                                 drop_armed_reg;
	accel_sample_fifo_pkg::frame_t        pend_reg;
	logic                                 pend_valid_reg;
	accel_sample_fifo_pkg::read_state_t   rs_reg, rs_next;
	logic [2:0]                           off_reg, off_next;
	logic                                 over_reg, over_next;
	logic [23:0]                          time_reg;
	logic                                 session_reg, session_next;
	logic                                 full_lat_reg, wtm_lat_reg;

	// APB decode
	wire [7:0] idx        = paddr[9:2];
	wire       prep       = psel & penable & ~pready;
	wire       done       = psel & penable & pready;
	wire       wr_done    = done & pwrite;
	wire       data_rd    = done & ~pwrite & (idx == accel_sample_fifo_pkg::IDX_DATA);
	wire       status_rd  = done & ~pwrite & (idx == accel_sample_fifo_pkg::IDX_STATUS);
	wire       data_prep  = prep & ~pwrite & (idx == accel_sample_fifo_pkg::IDX_DATA);
	wire [7:0] wb         = pwdata[7:0];
	wire       soft_reset = wr_done & (idx == accel_sample_fifo_pkg::IDX_SOFT_RESET)
		& (wb == accel_sample_fifo_pkg::SOFT_RESET_CMD);
	wire       mapped     = (idx == accel_sample_fifo_pkg::IDX_STATUS)
		| (idx == accel_sample_fifo_pkg::IDX_LENGTH_LO) | (idx == accel_sample_fifo_pkg::IDX_LENGTH_HI)
		| (idx == accel_sample_fifo_pkg::IDX_DATA) | (idx == accel_sample_fifo_pkg::IDX_FILTER_CFG)
		| (idx == accel_sample_fifo_pkg::IDX_RANGE_CFG) | (idx == accel_sample_fifo_pkg::IDX_DOWNS)
		| (idx == accel_sample_fifo_pkg::IDX_WTM_LO) | (idx == accel_sample_fifo_pkg::IDX_WTM_HI)
		| (idx == accel_sample_fifo_pkg::IDX_MODE) | (idx == accel_sample_fifo_pkg::IDX_SOURCE)
		| (idx == accel_sample_fifo_pkg::IDX_PIN_SELECT)
		| (idx == accel_sample_fifo_pkg::IDX_PIN_ROUTING)
		| (idx == accel_sample_fifo_pkg::IDX_SOFT_RESET);

	// Configuration change detection
	wire wr_downs  = wr_done & (idx == accel_sample_fifo_pkg::IDX_DOWNS);
	wire chg_filt  = (wr_done & (idx == accel_sample_fifo_pkg::IDX_FILTER_CFG) & (wb != filter_reg))
		| (wr_downs & (wb[6:4] != downs_reg[6:4]));
	wire chg_range = wr_done & (idx == accel_sample_fifo_pkg::IDX_RANGE_CFG) & (wb != range_reg);

	// Down-sampled store tick
	wire acc_en     = source_reg[accel_sample_fifo_pkg::SRC_ACC_EN_BIT];
	wire store_tick = odr_tick & acc_en
		& ((tick_cnt_reg & downs_mask(active_downs_reg)) == 7'h00);
	wire stop_mode  = mode_reg[accel_sample_fifo_pkg::MODE_STOP_BIT];

	// Pin tags
	wire tag_a = irq_pin_a_in & pin_sel_reg[0] & source_reg[accel_sample_fifo_pkg::SRC_PIN_A_BIT];
	wire tag_b = irq_pin_b_in & pin_sel_reg[1] & source_reg[accel_sample_fifo_pkg::SRC_PIN_B_BIT];
	wire [7:0] data_hdr = {accel_sample_fifo_pkg::SIG_DATA, tag_b, tag_a};

	// Frames offered to the pending slot
	wire cfg_go   = (cfg_flags_reg != 2'b00) & ~pend_valid_reg & ~store_tick;
	wire drop_go  = store_tick & drop_armed_reg & ~sample_in.valid;
	wire data_go  = store_tick & sample_in.valid;
	wire new_frm  = drop_go | data_go;
	wire [55:0] cfg_bytes  = {40'h0, 6'h00, cfg_flags_reg, accel_sample_fifo_pkg::SIG_CFG, 2'b00};
	wire [55:0] drop_bytes = {48'h0, accel_sample_fifo_pkg::SIG_DROP, 2'b00};
	wire [55:0] data_bytes = {sample_in.data, data_hdr};

	// Read engine results
	logic [7:0] rd_byte;
	logic       rd_frame_done, skip_clr;
	wire  [2:0] cur_len  = stored_len(mem[rd_ptr_reg]);
	wire  [7:0] cur_byte = mem[AW'(rd_ptr_reg + AW'(off_reg))];

	// Store or drop decisions, held off while a data read is being prepared
	wire [AW:0] room   = CAP - fill_reg;
	wire        fits   = pend_valid_reg & (room >= (AW+1)'(pend_reg.len));
	wire        write  = fits & ~data_prep & ~soft_reset;
	wire        no_fit = pend_valid_reg & ~fits & ~data_prep & ~soft_reset;
	wire        evict  = no_fit & ~stop_mode & (fill_reg != '0) & ~rd_frame_done;
	wire        reject = no_fit & stop_mode;
	wire        lost   = new_frm & pend_valid_reg & ~write & ~reject;
	wire        overflow = evict | reject | lost;
	wire [2:0]  evict_len = cur_len;

	// Fill level with whole-frame updates
	always_comb begin
		fill_next = fill_reg;
		if (write)
			fill_next = fill_next + (AW+1)'(pend_reg.len);
		if (rd_frame_done)
			fill_next = fill_next - (AW+1)'(cur_len);
		if (evict)
			fill_next = fill_next - (AW+1)'(evict_len);
	end

	// Burst session: back-to-back data-port reads under one psel
	always_comb begin
		session_next = session_reg;
		if (data_rd)
			session_next = 1'b1;
		else if (!psel || (done && !data_rd))
			session_next = 1'b0;
	end

	// Read engine
	always_comb begin
		rd_byte       = 8'h00;
		rs_next       = rs_reg;
		off_next      = off_reg;
		over_next     = over_reg;
		rd_frame_done = 1'b0;
		skip_clr      = 1'b0;
		case (rs_reg)
			accel_sample_fifo_pkg::RS_IDLE: begin
				if (skip_cnt_reg != 8'h00) begin
					rd_byte = {accel_sample_fifo_pkg::SIG_SKIP, 2'b00};
					rs_next = accel_sample_fifo_pkg::RS_SKIP;
				end else if (fill_reg != '0) begin
					rd_byte  = cur_byte;
					off_next = 3'd1;
					rs_next  = accel_sample_fifo_pkg::RS_FRAME;
				end else begin
					rd_byte   = over_reg ? accel_sample_fifo_pkg::OVERREAD_LO
						: accel_sample_fifo_pkg::OVERREAD_HI;
					over_next = ~over_reg;
				end
			end
			accel_sample_fifo_pkg::RS_SKIP: begin
				rd_byte  = skip_cnt_reg;
				skip_clr = 1'b1;
				rs_next  = accel_sample_fifo_pkg::RS_IDLE;
			end
			accel_sample_fifo_pkg::RS_FRAME: begin
				rd_byte = cur_byte;
				if (off_reg == cur_len - 3'd1) begin
					rd_frame_done = data_rd;
					off_next      = 3'd0;
					rs_next       = (fill_reg == (AW+1)'(cur_len)) ?
						accel_sample_fifo_pkg::RS_TIME : accel_sample_fifo_pkg::RS_IDLE;
				end else begin
					off_next = off_reg + 3'd1;
				end
			end
			accel_sample_fifo_pkg::RS_TIME: begin
				case (off_reg)
					3'd0:    rd_byte = {accel_sample_fifo_pkg::SIG_TIME, 2'b00};
					3'd1:    rd_byte = time_reg[7:0];
					3'd2:    rd_byte = time_reg[15:8];
					default: rd_byte = time_reg[23:16];
				endcase
				if (off_reg == accel_sample_fifo_pkg::LEN_TIME - 3'd1) begin
					off_next = 3'd0;
					rs_next  = accel_sample_fifo_pkg::RS_IDLE;
				end else begin
					off_next = off_reg + 3'd1;
				end
			end
			default: rs_next = accel_sample_fifo_pkg::RS_IDLE;
		endcase
		if (!data_rd) begin
			rs_next   = rs_reg;
			off_next  = off_reg;
			over_next = over_reg;
			skip_clr  = 1'b0;
		end
		if (!session_next && (rs_reg == accel_sample_fifo_pkg::RS_FRAME
			|| rs_reg == accel_sample_fifo_pkg::RS_TIME)) begin
			rs_next  = accel_sample_fifo_pkg::RS_IDLE;
			off_next = 3'd0;
		end
		if (evict && rs_reg == accel_sample_fifo_pkg::RS_FRAME) begin
			rs_next  = accel_sample_fifo_pkg::RS_IDLE;
			off_next = 3'd0;
		end
		if (!session_next)
			over_next = 1'b0;
		if (soft_reset) begin
			rs_next   = accel_sample_fifo_pkg::RS_IDLE;
			off_next  = 3'd0;
			over_next = 1'b0;
		end
	end

	// Interrupt conditions
	wire full_cond = (fill_reg > FULL_THR) & ~session_reg;
	wire wtm_cond  = ({2'b00, fill_reg} >= wtm_reg) & ~session_reg;
	wire full_clr  = status_rd & (fill_reg <= FULL_THR);
	wire wtm_clr   = status_rd & ({2'b00, fill_reg} < wtm_reg);

	// Register read mux
	wire [13:0] length14 = 14'(fill_reg);
	wire [7:0]  reg_rd =
		(idx == accel_sample_fifo_pkg::IDX_STATUS)      ? {6'h00, wtm_lat_reg, full_lat_reg} :
		(idx == accel_sample_fifo_pkg::IDX_LENGTH_LO)   ? length14[7:0] :
		(idx == accel_sample_fifo_pkg::IDX_LENGTH_HI)   ? {2'b00, length14[13:8]} :
		(idx == accel_sample_fifo_pkg::IDX_DATA)        ? rd_byte :
		(idx == accel_sample_fifo_pkg::IDX_FILTER_CFG)  ? filter_reg :
		(idx == accel_sample_fifo_pkg::IDX_RANGE_CFG)   ? range_reg :
		(idx == accel_sample_fifo_pkg::IDX_DOWNS)       ? downs_reg :
		(idx == accel_sample_fifo_pkg::IDX_WTM_LO)      ? wtm_reg[7:0] :
		(idx == accel_sample_fifo_pkg::IDX_WTM_HI)      ? {3'b000, wtm_reg[12:8]} :
		(idx == accel_sample_fifo_pkg::IDX_MODE)        ? mode_reg :
		(idx == accel_sample_fifo_pkg::IDX_SOURCE)      ? source_reg :
		(idx == accel_sample_fifo_pkg::IDX_PIN_SELECT)  ? pin_sel_reg :
		(idx == accel_sample_fifo_pkg::IDX_PIN_ROUTING) ? routing_reg : 8'h00;

	// Storage, no reset
	always_ff @(posedge pclk) begin
		for (int i = 0; i < 7; i++) begin
			if (write && 3'(i) < pend_reg.len)
				mem[AW'(wr_ptr_reg + AW'(i))] <= pend_reg.bytes[i*8 +: 8];
		end
	end

	// APB answer, one wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= prep;
			pslverr <= prep & ~mapped;
			if (prep)
				prdata <= {24'h0, pwrite ? 8'h00 : reg_rd};
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			downs_reg   <= accel_sample_fifo_pkg::RST_DOWNS;
			mode_reg    <= accel_sample_fifo_pkg::RST_MODE;
			source_reg  <= accel_sample_fifo_pkg::RST_SOURCE;
			wtm_reg     <= accel_sample_fifo_pkg::RST_WTM;
			filter_reg  <= accel_sample_fifo_pkg::RST_CFG;
			range_reg   <= accel_sample_fifo_pkg::RST_CFG;
			pin_sel_reg <= accel_sample_fifo_pkg::RST_CFG;
			routing_reg <= accel_sample_fifo_pkg::RST_PIN_ROUTING;
		end else if (wr_done) begin
			if (idx == accel_sample_fifo_pkg::IDX_DOWNS)
				downs_reg <= {1'b1, wb[6:4], 4'h0};
			else if (idx == accel_sample_fifo_pkg::IDX_MODE)
				mode_reg <= {6'h00, 1'b1, wb[0]};
			else if (idx == accel_sample_fifo_pkg::IDX_SOURCE)
				source_reg <= {1'b0, wb[6], 1'b0, 1'b1, wb[3:2], 2'b00};
			else if (idx == accel_sample_fifo_pkg::IDX_WTM_LO)
				wtm_reg[7:0] <= wb;
			else if (idx == accel_sample_fifo_pkg::IDX_WTM_HI)
				wtm_reg[12:8] <= wb[4:0];
			else if (idx == accel_sample_fifo_pkg::IDX_FILTER_CFG)
				filter_reg <= wb;
			else if (idx == accel_sample_fifo_pkg::IDX_RANGE_CFG)
				range_reg <= wb;
			else if (idx == accel_sample_fifo_pkg::IDX_PIN_SELECT)
				pin_sel_reg <= {6'h00, wb[1:0]};
			else if (idx == accel_sample_fifo_pkg::IDX_PIN_ROUTING)
				routing_reg <= {2'b00, wb[5:4], 2'b00, wb[1:0]};
		end
	end

	// Buffer control state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_downs_reg <= 3'd0;
			tick_cnt_reg     <= 7'h00;
			wr_ptr_reg       <= '0;
			rd_ptr_reg       <= '0;
			fill_reg         <= '0;
			skip_cnt_reg     <= 8'h00;
			cfg_flags_reg    <= 2'b00;
			drop_armed_reg   <= 1'b0;
			pend_reg         <= '0;
			pend_valid_reg   <= 1'b0;
			rs_reg           <= accel_sample_fifo_pkg::RS_IDLE;
			off_reg          <= 3'd0;
			over_reg         <= 1'b0;
			time_reg         <= 24'h0;
			session_reg      <= 1'b0;
		end else begin
			rs_reg      <= rs_next;
			off_reg     <= off_next;
			over_reg    <= over_next;
			session_reg <= session_next;
			if (odr_tick)
				tick_cnt_reg <= tick_cnt_reg + 7'h01;
			if (data_rd && rd_frame_done && rs_next == accel_sample_fifo_pkg::RS_TIME)
				time_reg <= sensor_time;
			if (chg_filt || chg_range)
				cfg_flags_reg <= cfg_flags_reg | {chg_range, chg_filt};
			else if (cfg_go)
				cfg_flags_reg <= 2'b00;
			if (cfg_go)
				active_downs_reg <= downs_reg[6:4];
			if (cfg_go)
				drop_armed_reg <= 1'b1;
			else if (store_tick)
				drop_armed_reg <= 1'b0;
			if (write || reject)
				pend_valid_reg <= 1'b0;
			if (write)
				wr_ptr_reg <= AW'(wr_ptr_reg + AW'(pend_reg.len));
			if (rd_frame_done)
				rd_ptr_reg <= AW'(rd_ptr_reg + AW'(cur_len));
			else if (evict)
				rd_ptr_reg <= AW'(rd_ptr_reg + AW'(evict_len));
			if (!pend_valid_reg || write || reject) begin
				if (new_frm) begin
					pend_valid_reg <= 1'b1;
					pend_reg.len   <= data_go ? accel_sample_fifo_pkg::LEN_DATA
						: accel_sample_fifo_pkg::LEN_SHORT;
					pend_reg.bytes <= data_go ? data_bytes : drop_bytes;
				end else if (cfg_go) begin
					pend_valid_reg <= 1'b1;
					pend_reg.len   <= accel_sample_fifo_pkg::LEN_SHORT;
					pend_reg.bytes <= cfg_bytes;
				end
			end
			// Overflow count wins over the clear by the skip frame
			if (overflow)
				skip_cnt_reg <= (skip_clr || skip_cnt_reg == 8'h00) ? 8'h01 :
					(skip_cnt_reg == accel_sample_fifo_pkg::SKIP_SATURATE) ?
					accel_sample_fifo_pkg::SKIP_SATURATE : skip_cnt_reg + 8'h01;
			else if (skip_clr)
				skip_cnt_reg <= 8'h00;
			fill_reg <= fill_next;
			if (soft_reset) begin
				wr_ptr_reg     <= '0;
				rd_ptr_reg     <= '0;
				fill_reg       <= '0;
				skip_cnt_reg   <= 8'h00;
				pend_valid_reg <= 1'b0;
			end
		end
	end

	// Latched interrupts and pin routing; set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_lat_reg  <= 1'b0;
			wtm_lat_reg   <= 1'b0;
			irq_pin_a_out <= 1'b0;
			irq_pin_b_out <= 1'b0;
		end else begin
			full_lat_reg  <= full_cond | (full_lat_reg & ~full_clr);
			wtm_lat_reg   <= wtm_cond | (wtm_lat_reg & ~wtm_clr);
			irq_pin_a_out <= (full_lat_reg & routing_reg[accel_sample_fifo_pkg::MAP_A_FULL_BIT])
				| (wtm_lat_reg & routing_reg[accel_sample_fifo_pkg::MAP_A_WTM_BIT]);
			irq_pin_b_out <= (full_lat_reg & routing_reg[accel_sample_fifo_pkg::MAP_B_FULL_BIT])
				| (wtm_lat_reg & routing_reg[accel_sample_fifo_pkg::MAP_B_WTM_BIT]);
		end
	end

endmodule : accel_sample_fifo

/* rtl/accel_sample_fifo_pkg.sv */
/*
 * Package for the accelerometer sample buffer: register indices, reset values,
 * frame signatures and lengths, and the carrier types.
 * Assumes a 32-bit APB host; byte address of a register is four times its index.
 */
package accel_sample_fifo_pkg;

	// Register indices (byte address = index * 4)
	localparam logic [7:0] IDX_STATUS      = 8'h1d;
	localparam logic [7:0] IDX_LENGTH_LO   = 8'h24;
	localparam logic [7:0] IDX_LENGTH_HI   = 8'h25;
	localparam logic [7:0] IDX_DATA        = 8'h26;
	localparam logic [7:0] IDX_FILTER_CFG  = 8'h40;
	localparam logic [7:0] IDX_RANGE_CFG   = 8'h41;
	localparam logic [7:0] IDX_DOWNS       = 8'h45;
	localparam logic [7:0] IDX_WTM_LO      = 8'h46;
	localparam logic [7:0] IDX_WTM_HI      = 8'h47;
	localparam logic [7:0] IDX_MODE        = 8'h48;
	localparam logic [7:0] IDX_SOURCE      = 8'h49;
	localparam logic [7:0] IDX_PIN_SELECT  = 8'h53;
	localparam logic [7:0] IDX_PIN_ROUTING = 8'h58;
	localparam logic [7:0] IDX_SOFT_RESET  = 8'h7e;

	// Reset values
	localparam logic [7:0]  RST_DOWNS       = 8'h80;
	localparam logic [7:0]  RST_MODE        = 8'h02;
	localparam logic [7:0]  RST_SOURCE      = 8'h10;
	localparam logic [12:0] RST_WTM         = 13'h0200;
	localparam logic [7:0]  RST_PIN_ROUTING = 8'h00;
	localparam logic [7:0]  RST_CFG         = 8'h00;

	// Field positions
	localparam int MODE_STOP_BIT   = 0;
	localparam int SRC_ACC_EN_BIT  = 6;
	localparam int SRC_PIN_A_BIT   = 3;
	localparam int SRC_PIN_B_BIT   = 2;
	localparam int DOWNS_LSB       = 4;
	localparam int MAP_A_FULL_BIT  = 0;
	localparam int MAP_A_WTM_BIT   = 1;
	localparam int MAP_B_FULL_BIT  = 4;
	localparam int MAP_B_WTM_BIT   = 5;
	localparam int CFG_FILTER_BIT  = 0;
	localparam int CFG_RANGE_BIT   = 1;

	// Commands and patterns
	localparam logic [7:0] SOFT_RESET_CMD = 8'hb0;
	localparam logic [7:0] OVERREAD_HI    = 8'h80;
	localparam logic [7:0] OVERREAD_LO    = 8'h00;
	localparam logic [7:0] SKIP_SATURATE  = 8'hff;

	// Header signatures, upper six bits
	localparam logic [5:0] SIG_DATA = 6'b100001;
	localparam logic [5:0] SIG_SKIP = 6'b010000;
	localparam logic [5:0] SIG_TIME = 6'b010001;
	localparam logic [5:0] SIG_CFG  = 6'b010010;
	localparam logic [5:0] SIG_DROP = 6'b010100;

	// Frame lengths in bytes
	localparam logic [2:0] LEN_DATA  = 3'd7;
	localparam logic [2:0] LEN_SHORT = 3'd2;
	localparam logic [2:0] LEN_TIME  = 3'd4;

	// Room kept free above the full threshold: two data frames
	localparam int FULL_MARGIN = 14;

	typedef struct packed {
		logic [47:0] data;
		logic        valid;
	} sensor_sample_t;

	typedef struct packed {
		logic [2:0]  len;
		logic [55:0] bytes;
	} frame_t;

	typedef enum logic [1:0] {
		RS_IDLE  = 2'b00,
		RS_SKIP  = 2'b01,
		RS_FRAME = 2'b10,
		RS_TIME  = 2'b11
	} read_state_t;

endpackage : accel_sample_fifo_pkg

/* tb/accel_sample_fifo_bench.sv */
/*
 * Self-checking bench: APB register and data-port sequences.
 * Assumes the sensor stand-in and the bound property checker.
 */
`timescale 1ns/1ps
module accel_sample_fifo_bench;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic        pwrite = 1'h0, fire = 1'h0, spoil = 1'h0, pin_lvl = 1'h0, pready, pslverr;
	logic        tick, irq_a, irq_b, err;
	logic [9:0]  paddr = 10'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [7:0]  seed = 8'h0, rd;
	logic [23:0] stime, tcap;
	int          miscompares = 0, checks = 0, cyc = 0;
	logic [7:0]  ridx [6] = '{8'h48, 8'h49, 8'h45, 8'h46, 8'h47, 8'h58};
	logic [7:0]  rval [6] = '{8'h02, 8'h10, 8'h80, 8'h00, 8'h02, 8'h00};
	accel_sample_fifo_pkg::sensor_sample_t smp;

	always #5 pclk = ~pclk;

	accel_sample_fifo dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .odr_tick(tick), .sample_in(smp), .sensor_time(stime),
		.irq_pin_a_in(pin_lvl), .irq_pin_b_in(pin_lvl), .irq_pin_a_out(irq_a),
		.irq_pin_b_out(irq_b));
	accel_sensor_model model_u (.pclk(pclk), .fire(fire), .seed(seed), .spoil(spoil),
		.odr_tick(tick), .sample(smp), .time_now(stime));

	task tally_and_finish;
		if (miscompares == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task chk(input string n, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	// Single transfer; without last, psel stays up for the next one
	task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd, input logic last);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata[7:0];
		err = pslverr;
		penable <= 1'h0;
		if (last) begin
			psel <= 1'h0;
			@(posedge pclk);
		end
	endtask : apb

	task rc(input string n, input logic [7:0] idx, input logic [7:0] exp, input logic last);
		apb(1'h0, idx, 8'h0, last);
		chk(n, exp, rd);
	endtask : rc

	task pulse(input logic [7:0] s);
		fire <= 1'h1;
		seed <= s;
		@(posedge pclk);
		fire <= 1'h0;
		repeat (3) @(posedge pclk);
	endtask : pulse

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish;
		end
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		for (int i = 0; i < 6; i++) rc("reset value", ridx[i], rval[i], 1'h1);
		apb(1'h0, 8'h00, 8'h00, 1'h1);
		chk("unmapped error", 8'h01, {7'h0, err});
		rc("overread", 8'h26, 8'h80, 1'h0);
		rc("overread", 8'h26, 8'h00, 1'h1);
		apb(1'h1, 8'h49, 8'h58, 1'h1);
		apb(1'h1, 8'h53, 8'h01, 1'h1);
		pin_lvl <= 1'h1;
		pulse(8'h10);
		pin_lvl <= 1'h0;
		rc("fill lo", 8'h24, 8'h07, 1'h1);
		rc("data header", 8'h26, 8'h85, 1'h0);
		for (int j = 0; j < 6; j++) rc("payload", 8'h26, 8'h10 + j[7:0], 1'h0);
		tcap = stime;
		rc("time header", 8'h26, 8'h44, 1'h0);
		for (int j = 0; j < 3; j++) rc("time byte", 8'h26, tcap[8*j +: 8], 1'h0);
		rc("overread", 8'h26, 8'h80, 1'h1);
		apb(1'h1, 8'h58, 8'h01, 1'h1);
		for (int m = 1; m >= 0; m--) begin
			apb(1'h1, 8'h7e, 8'hb0, 1'h1);
			apb(1'h1, 8'h48, m[7:0], 1'h1);
			for (int i = 0; i < 150; i++) pulse(i[7:0]);
			rc("fill lo", 8'h24, 8'hfe, 1'h1);
			rc("fill hi", 8'h25, 8'h03, 1'h1);
			chk("full pin", 8'h01, {7'h0, irq_a});
			chk("unrouted pin", 8'h00, {7'h0, irq_b});
			rc("skip header", 8'h26, 8'h40, 1'h0);
			rc("skip count", 8'h26, 8'h04, 1'h0);
			rc("data header", 8'h26, 8'h84, 1'h0);
			rc("oldest kept", 8'h26, m ? 8'h00 : 8'h04, 1'h1);
		end
		rc("retry header", 8'h26, 8'h84, 1'h0);
		rc("retry byte", 8'h26, 8'h04, 1'h1);
		apb(1'h1, 8'h7e, 8'hb0, 1'h1);
		rc("fill after clear", 8'h24, 8'h00, 1'h1);
		rc("status", 8'h1d, 8'h03, 1'h1);
		repeat (2) @(posedge pclk);
		chk("full pin", 8'h00, {7'h0, irq_a});
		apb(1'h1, 8'h41, 8'h01, 1'h1);
		spoil <= 1'h1;
		pulse(8'h30);
		spoil <= 1'h0;
		rc("cfg header", 8'h26, 8'h48, 1'h0);
		rc("range flag", 8'h26, 8'h02, 1'h0);
		rc("drop header", 8'h26, 8'h50, 1'h0);
		rc("drop byte", 8'h26, 8'h00, 1'h1);
		apb(1'h1, 8'h45, 8'h90, 1'h1);
		for (int i = 0; i < 4; i++) pulse(8'h20);
		rc("fill lo", 8'h24, 8'h10, 1'h1);
		rc("cfg header", 8'h26, 8'h48, 1'h0);
		rc("cfg flags", 8'h26, 8'h01, 1'h1);
		tally_and_finish;
	end
endmodule : accel_sample_fifo_bench

/* tb/accel_sample_fifo_props.sv */
/*
 * APB timing properties of the sample buffer.
 * Assumes binding to the buffer top; sees its ports only.
 */
`timescale 1ns/1ps
module accel_sample_fifo_props (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [9:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable; endsequence
	AST_WAIT: assert property (s_setup ##1 s_access |=> pready) else $error("no ready");
	AST_EARLY: assert property (s_setup ##1 s_access |-> !pready) else $error("early");
	AST_PULSE: assert property (pready |=> !pready) else $error("ready held");
	AST_QUAL: assert property (pready |-> s_access) else $error("stray ready");
	AST_ERR: assert property (pslverr |-> pready) else $error("stray error");
	AST_UNMAP: assert property (pready && paddr[9:2] == 8'h00 |-> pslverr) else $error("no err");
	AST_DATA: assert property (pready && paddr[9:2] == 8'h26 |-> !pslverr && prdata[31:8] == 24'h0)
		else $error("data port");
	AST_HOLD: assert property (pready |=> $stable(prdata)) else $error("data moved");
endmodule : accel_sample_fifo_props

bind accel_sample_fifo accel_sample_fifo_props props_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));

/* tb/accel_sensor_model.sv */
/*
 * Sensor stand-in: one sample tick per fire pulse, bytes counted up from a seed.
 * Assumes fire is a one-cycle pulse synchronous to pclk.
 */
`timescale 1ns/1ps
module accel_sensor_model (
	// Clock
	input  wire logic                             pclk,
	// Bench control
	input  wire logic                             fire,
	input  wire logic [7:0]                       seed,
	input  wire logic                             spoil,
	// Sensor side
	output logic                                  odr_tick,
	output accel_sample_fifo_pkg::sensor_sample_t sample,
	output logic [23:0]                           time_now
);
	initial begin
		odr_tick = 1'h0;
		sample = '0;
		time_now = 24'h0;
	end
	always @(posedge pclk) begin
		odr_tick <= fire;
		time_now <= time_now + 24'h1;
		sample.valid <= ~spoil;
		for (int n = 0; n < 6; n++) sample.data[8*n +: 8] <= seed + n[7:0];
	end
endmodule : accel_sensor_model
